// ---- logic/cha_pkg.sv ----
// Purpose: shared constants and types for the charger status/config register bank
// Assumes: 250 MHz core clock, byte-wide registers reached over the two-wire serial port
// Notes:   every offset, field position, reset value and timing count lives here
package cha_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] REG_STATUS_ADDR = 8'h03;
  localparam logic [7:0] REG_CONFIG_ADDR = 8'h04;
  localparam logic [7:0] STATUS_RESET    = 8'h00;
  localparam logic [7:0] CONFIG_RESET    = 8'hB1;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;
  // serial slave address, value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

  // status byte bit positions
  localparam int ST_THERMAL_REG   = 7;
  localparam int ST_POWER_PATH    = 6;
  localparam int ST_THERMAL_TIMER_FREEZE  = 5;
  localparam int ST_TERM_REACHED  = 4;
  localparam int ST_ACTIVE        = 3;
  localparam int ST_CHG_TIMEOUT   = 2;
  localparam int ST_PRE_TIMEOUT   = 1;
  localparam int ST_BATT_TEMP_ERR = 0;

  // config byte bit positions
  localparam int CF_TIMER_HI   = 7;
  localparam int CF_TIMER_LO   = 6;
  localparam int CF_TIMERS_ON  = 5;
  localparam int CF_CURVE_SEL  = 4;
  localparam int CF_CHG_RESET  = 3;
  localparam int CF_TERM_OFF   = 2;
  localparam int CF_FREEZE     = 1;
  localparam int CF_CHARGER_ON = 0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam longint CLK_PERIOD_PS  = 4000;
  localparam longint TICK_PERIOD_MS = 1000;
  localparam longint PS_PER_MS      = 1000000000;
  localparam longint TICK_CYCLES    = (TICK_PERIOD_MS * PS_PER_MS) / CLK_PERIOD_PS;
  localparam int     TMR_W          = 15;
  localparam int     SEC_PER_MIN    = 60;
  localparam int     SEC_PER_HOUR   = 3600;
  localparam int     PRECHG_TIME_MIN = 30;
  localparam int     FAST_SEL0_H    = 4;
  localparam int     FAST_SEL1_H    = 5;
  localparam int     FAST_SEL2_H    = 6;
  localparam int     FAST_SEL3_H    = 8;
  localparam logic [TMR_W-1:0] PRECHG_LIMIT_S = TMR_W'(PRECHG_TIME_MIN * SEC_PER_MIN);

  // ****************************************************************
  // types and helpers
  // ****************************************************************
  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_ADDR = 3'b001, I_ACK = 3'b010,
    I_WR   = 3'b011, I_RD   = 3'b100, I_RACK = 3'b101
  } cha_link_e;

  typedef enum logic [2:0] {
    C_IDLE = 3'b000, C_PRE = 3'b001, C_FAST = 3'b010,
    C_DONE = 3'b011, C_FAULT = 3'b100
  } cha_chg_e;

  // fast-charge safety time in seconds from the two-bit field
  function automatic logic [TMR_W-1:0] fast_limit_s(input logic [1:0] sel);
    int h;
    h = (sel == 2'h0) ? FAST_SEL0_H : (sel == 2'h1) ? FAST_SEL1_H :
        (sel == 2'h2) ? FAST_SEL2_H : FAST_SEL3_H;
    return TMR_W'(h * SEC_PER_HOUR);
  endfunction : fast_limit_s

endpackage : cha_pkg

// ---- logic/cha_tick_gen.sv ----
// Purpose: one-cycle enable pulse at the safety timer base rate
// Assumes: single core clock
// Notes:   CYCLES is shortened in simulation
`timescale 1ns/10ps
module cha_tick_gen #(
  parameter int unsigned CYCLES = 32'd250000000
) (
  input  wire logic clk,
  input  wire logic srst,
  output logic      tick
);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;

  // free-running divider, pulse on wrap
  always_comb begin
    if (cnt_r >= CYCLES - 32'd1) begin
      cnt_nxt  = 32'h0000_0000;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt  = cnt_r + 32'd1;
      tick_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule : cha_tick_gen

// ---- logic/cha_safety_tmr.sv ----
// Purpose: safety timer counting base ticks up to a limit
// Assumes: run is already gated by enable, freeze and tick
// Notes:   count holds while run is low, so a freeze keeps progress
`timescale 1ns/10ps
module cha_safety_tmr (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic                     clear,
  input  wire logic                     run,
  input  wire logic [cha_pkg::TMR_W-1:0] limit,
  output logic                          expired
);
  logic [cha_pkg::TMR_W-1:0] cnt_r;
  logic [cha_pkg::TMR_W-1:0] cnt_nxt;
  logic                      exp_r;
  logic                      exp_nxt;

  // clear wins over counting; expiry is sticky until clear
  always_comb begin
    cnt_nxt = cnt_r;
    exp_nxt = exp_r;
    if (clear) begin
      cnt_nxt = '0;
      exp_nxt = 1'b0;
    end else if (run && !exp_r) begin
      cnt_nxt = cnt_r + 1'b1;
      exp_nxt = (cnt_nxt >= limit);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expired = exp_r;
endmodule : cha_safety_tmr

// ---- logic/cha_charger_regs.sv ----
// Purpose: charger status and configuration registers with charge sequencing
// Assumes: scl/sda arrive synchronous to clk; analog loops report as levels
// Notes:   status byte is rebuilt every cycle from the sequencer state
//
// What this block does
// - status bit 7 shows thermal current reduction
// - status bit 6 shows power-path loop limiting
// - status bit 5 shows temperature charge hold-off
// - status bit 4 set at current termination
// - status bit 3 set while actively charging
// - status bit 2 on any timer expiry, stop
// - status bit 1 on precharge expiry, stop
// - status bit 0 on missing/out-of-range thermistor
// - config resets 0xB1; timer field 4/5/6/8h
// - config bit 5 enables both safety timers
// - config bit 4 selects thermistor curve
// - config bit 2 disables current termination
// - config bit 1 freezes both timers
// - config bit 0 enables the charger
// - config at address 0x04, reset 0xB1
// - status at address 0x03, reset 0x00
`timescale 1ns/10ps
module cha_charger_regs #(
  parameter int unsigned TICK_CYCLES = 32'(cha_pkg::TICK_CYCLES),
  parameter logic [6:0]  DEV_ADDR    = cha_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic supply_ok,
  input  wire logic batt_low_v,
  input  wire logic term_current_det,
  input  wire logic thermal_loop_act,
  input  wire logic power_path_act,
  input  wire logic ntc_present,
  input  wire logic batt_temp_ok,
  output logic      charge_enable,
  output logic      precharge_mode,
  output logic      thermistor_curve_sel
);

  // ****************************************************************
  // serial line sampling
  // ****************************************************************
  logic scl_q_r, sda_q_r;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  // previous samples give edges and start/stop framing
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
    end
  end
  assign scl_rise   = scl_in && !scl_q_r;
  assign scl_fall   = !scl_in && scl_q_r;
  assign start_cond = scl_in && scl_q_r && sda_q_r && !sda_in;
  assign stop_cond  = scl_in && scl_q_r && !sda_q_r && sda_in;

  // ****************************************************************
  // register storage declarations
  // ****************************************************************
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] status_r, status_nxt;
  logic       wr_stb;
  logic [7:0] wr_data;

  // read multiplexer, used when each read byte is loaded
  function automatic logic [7:0] read_mux(input logic [7:0] a, input logic [7:0] st, input logic [7:0] cf);
    if (a == cha_pkg::REG_STATUS_ADDR) return st;
    if (a == cha_pkg::REG_CONFIG_ADDR) return cf;
    return cha_pkg::UNMAPPED_READ;
  endfunction : read_mux

  // ****************************************************************
  // serial slave
  // ****************************************************************
  cha_pkg::cha_link_e ist_r, ist_nxt;
  logic [3:0]         bcnt_r, bcnt_nxt;
  logic [7:0]         shift_r, shift_nxt;
  logic [7:0]         ptr_r, ptr_nxt;
  logic               rw_r, rw_nxt;
  logic               ptr_phase_r, ptr_phase_nxt;
  logic               oe_r, oe_nxt;
  logic [7:0]         rd_byte;
  assign rd_byte = read_mux(ptr_r, status_r, cfg_r);

  // bits shift in on scl rise, the line changes only while scl is low
  always_comb begin
    ist_nxt       = ist_r;
    bcnt_nxt      = bcnt_r;
    shift_nxt     = shift_r;
    ptr_nxt       = ptr_r;
    rw_nxt        = rw_r;
    ptr_phase_nxt = ptr_phase_r;
    oe_nxt        = oe_r;
    wr_stb        = 1'b0;
    wr_data       = shift_r;
    if (stop_cond) begin
      ist_nxt = cha_pkg::I_IDLE;
      oe_nxt  = 1'b0;
    end else if (start_cond) begin
      ist_nxt  = cha_pkg::I_ADDR;
      bcnt_nxt = 4'h0;
      oe_nxt   = 1'b0;
    end else begin
      unique case (ist_r)
        cha_pkg::I_IDLE: oe_nxt = 1'b0;
        cha_pkg::I_ADDR: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_in};
            bcnt_nxt  = bcnt_r + 4'h1;
          end else if (scl_fall && bcnt_r == 4'h8) begin
            if (shift_r[7:1] == DEV_ADDR) begin
              rw_nxt        = shift_r[0];
              ptr_phase_nxt = !shift_r[0];
              oe_nxt        = 1'b1;
              ist_nxt       = cha_pkg::I_ACK;
            end else begin
              ist_nxt = cha_pkg::I_IDLE;
            end
          end
        end
        cha_pkg::I_ACK: begin
          if (scl_fall) begin
            bcnt_nxt = 4'h0;
            if (rw_r) begin
              shift_nxt = rd_byte;
              oe_nxt    = !rd_byte[7];
              ptr_nxt   = ptr_r + 8'h01;
              ist_nxt   = cha_pkg::I_RD;
            end else begin
              oe_nxt  = 1'b0;
              ist_nxt = cha_pkg::I_WR;
            end
          end
        end
        cha_pkg::I_WR: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_in};
            bcnt_nxt  = bcnt_r + 4'h1;
          end else if (scl_fall && bcnt_r == 4'h8) begin
            if (ptr_phase_r) begin
              ptr_nxt       = shift_r;
              ptr_phase_nxt = 1'b0;
            end else begin
              wr_stb  = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
            end
            oe_nxt  = 1'b1;
            ist_nxt = cha_pkg::I_ACK;
          end
        end
        cha_pkg::I_RD: begin
          if (scl_rise) begin
            bcnt_nxt = bcnt_r + 4'h1;
          end else if (scl_fall) begin
            if (bcnt_r == 4'h8) begin
              oe_nxt  = 1'b0;
              ist_nxt = cha_pkg::I_RACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt    = !shift_r[6];
            end
          end
        end
        cha_pkg::I_RACK: begin
          // a high on the acknowledge clock ends the read burst
          if (scl_rise && sda_in) begin
            ist_nxt = cha_pkg::I_IDLE;
          end else if (scl_fall) begin
            bcnt_nxt  = 4'h0;
            shift_nxt = rd_byte;
            oe_nxt    = !rd_byte[7];
            ptr_nxt   = ptr_r + 8'h01;
            ist_nxt   = cha_pkg::I_RD;
          end
        end
        default: begin
          ist_nxt = cha_pkg::I_IDLE;
          oe_nxt  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ist_r       <= cha_pkg::I_IDLE;
      bcnt_r      <= 4'h0;
      shift_r     <= 8'h00;
      ptr_r       <= 8'h00;
      rw_r        <= 1'b0;
      ptr_phase_r <= 1'b0;
      oe_r        <= 1'b0;
    end else begin
      ist_r       <= ist_nxt;
      bcnt_r      <= bcnt_nxt;
      shift_r     <= shift_nxt;
      ptr_r       <= ptr_nxt;
      rw_r        <= rw_nxt;
      ptr_phase_r <= ptr_phase_nxt;
      oe_r        <= oe_nxt;
    end
  end

  // ****************************************************************
  // configuration register
  // ****************************************************************
  // only the config address takes writes; the status byte ignores them
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_stb && ptr_r == cha_pkg::REG_CONFIG_ADDR) begin
      cfg_nxt = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_r <= cha_pkg::CONFIG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ****************************************************************
  // safety timers
  // ****************************************************************
  logic                      tick, pre_exp, fast_exp;
  logic                      timers_on, freeze, hold, thermal_suspend_flag, batt_err;
  logic [cha_pkg::TMR_W-1:0] fast_limit;
  cha_pkg::cha_chg_e         cst_r, cst_nxt;

  assign timers_on  = cfg_r[cha_pkg::CF_TIMERS_ON];
  assign freeze     = cfg_r[cha_pkg::CF_FREEZE];
  assign fast_limit = cha_pkg::fast_limit_s(cfg_r[cha_pkg::CF_TIMER_HI:cha_pkg::CF_TIMER_LO]);
  // hold covers charger reset bit, charger off and loss of supply
  assign hold       = cfg_r[cha_pkg::CF_CHG_RESET] || !cfg_r[cha_pkg::CF_CHARGER_ON] || !supply_ok;
  assign batt_err   = !ntc_present || !batt_temp_ok;
  assign thermal_suspend_flag      = (cst_r == cha_pkg::C_PRE || cst_r == cha_pkg::C_FAST) && batt_err;

  cha_tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (.clk(clk), .srst(srst), .tick(tick));
  // timers also pause during thermal suspend, so held-off time is not charged against them
  cha_safety_tmr u_pre_tmr (
    .clk     (clk),
    .srst    (srst),
    .clear   (hold || cst_r != cha_pkg::C_PRE),
    .run     (tick && timers_on && !freeze && !thermal_suspend_flag),
    .limit   (cha_pkg::PRECHG_LIMIT_S),
    .expired (pre_exp)
  );

  cha_safety_tmr u_fast_tmr (
    .clk     (clk),
    .srst    (srst),
    .clear   (hold || cst_r != cha_pkg::C_FAST),
    .run     (tick && timers_on && !freeze && !thermal_suspend_flag),
    .limit   (fast_limit),
    .expired (fast_exp)
  );

  // ****************************************************************
  // charge sequencer and status
  // ****************************************************************
  logic termination_reached_flag_r, termination_reached_flag_nxt;
  logic chg_to_r, chg_to_nxt;
  logic pre_to_r, pre_to_nxt;
  logic charger_on_r, charger_on_nxt;
  logic pre_mode_r, pre_mode_nxt;
  logic active, curve_r, sda_out_r;

  // sequence restarts from idle whenever hold is asserted
  always_comb begin
    cst_nxt    = cst_r;
    termination_reached_flag_nxt  = termination_reached_flag_r;
    chg_to_nxt = chg_to_r;
    pre_to_nxt = pre_to_r;
    if (hold) begin
      cst_nxt    = cha_pkg::C_IDLE;
      termination_reached_flag_nxt  = 1'b0;
      chg_to_nxt = 1'b0;
      pre_to_nxt = 1'b0;
    end else begin
      unique case (cst_r)
        cha_pkg::C_IDLE: cst_nxt = batt_low_v ? cha_pkg::C_PRE : cha_pkg::C_FAST;
        cha_pkg::C_PRE: begin
          if (pre_exp && timers_on) begin
            cst_nxt    = cha_pkg::C_FAULT;
            pre_to_nxt = 1'b1;
            chg_to_nxt = 1'b1;
          end else if (!batt_low_v) begin
            cst_nxt = cha_pkg::C_FAST;
          end
        end
        cha_pkg::C_FAST: begin
          if (fast_exp && timers_on) begin
            cst_nxt    = cha_pkg::C_FAULT;
            chg_to_nxt = 1'b1;
          end else if (term_current_det && !thermal_suspend_flag && !cfg_r[cha_pkg::CF_TERM_OFF]) begin
            cst_nxt   = cha_pkg::C_DONE;
            termination_reached_flag_nxt = 1'b1;
          end
        end
        cha_pkg::C_DONE, cha_pkg::C_FAULT: cst_nxt = cst_r;       // terminal until the next hold
        default: begin
          cst_nxt = cha_pkg::C_IDLE;
        end
      endcase
    end
  end

  assign active = (cst_r == cha_pkg::C_PRE || cst_r == cha_pkg::C_FAST) && !thermal_suspend_flag;

  // status is rebuilt every cycle so a read always sees live state
  always_comb begin
    status_nxt                            = cha_pkg::STATUS_RESET;
    status_nxt[cha_pkg::ST_THERMAL_REG]   = active && thermal_loop_act;
    status_nxt[cha_pkg::ST_POWER_PATH]    = active && power_path_act;
    status_nxt[cha_pkg::ST_THERMAL_TIMER_FREEZE]  = thermal_suspend_flag;
    status_nxt[cha_pkg::ST_TERM_REACHED]  = termination_reached_flag_r;
    status_nxt[cha_pkg::ST_ACTIVE]        = active;
    status_nxt[cha_pkg::ST_CHG_TIMEOUT]   = chg_to_r;
    status_nxt[cha_pkg::ST_PRE_TIMEOUT]   = pre_to_r;
    status_nxt[cha_pkg::ST_BATT_TEMP_ERR] = batt_err;
    charger_on_nxt                            = active && !hold;
    pre_mode_nxt                          = cst_r == cha_pkg::C_PRE;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cst_r      <= cha_pkg::C_IDLE;
      termination_reached_flag_r    <= 1'b0;
      chg_to_r   <= 1'b0;
      pre_to_r   <= 1'b0;
      status_r   <= cha_pkg::STATUS_RESET;
      charger_on_r   <= 1'b0;
      pre_mode_r <= 1'b0;
      curve_r    <= cha_pkg::CONFIG_RESET[cha_pkg::CF_CURVE_SEL];
      sda_out_r  <= 1'b0;
    end else begin
      cst_r      <= cst_nxt;
      termination_reached_flag_r    <= termination_reached_flag_nxt;
      chg_to_r   <= chg_to_nxt;
      pre_to_r   <= pre_to_nxt;
      status_r   <= status_nxt;
      charger_on_r   <= charger_on_nxt;
      pre_mode_r <= pre_mode_nxt;
      curve_r    <= cfg_r[cha_pkg::CF_CURVE_SEL];
      sda_out_r  <= 1'b0;
    end
  end

  // open-drain line: data is always low, the enable does the signalling
  assign sda_out              = sda_out_r;
  assign sda_oe               = oe_r;
  assign charge_enable        = charger_on_r;
  assign precharge_mode       = pre_mode_r;
  assign thermistor_curve_sel = curve_r;
endmodule : cha_charger_regs

// ---- bench/cha_host_model.sv ----
// Purpose: host side of the two-wire bus
// Assumes: sda pulled up, a released line reads high
// Notes:   4 clk half periods, one above the minimum
`timescale 1ns/10ps
module cha_host_model (
  input  wire logic clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_m
);
  // ****************************************
  // bus phases
  // ****************************************
  initial {scl, sda_m} = 2'h3;
  // one phase, launched just after a rising edge
  task automatic ph(input logic c, input logic d);
    scl <= c;
    sda_m <= d;
    repeat (4) @(posedge clk);
  endtask : ph
  // start (s=0) or stop (s=1): sda moves while scl high
  task automatic cond(input logic s);
    ph(1'h0, !s);
    ph(1'h1, !s);
    ph(1'h1, s);
  endtask : cond
  // byte plus ack slot, msb first; the wire is sampled late in scl high
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      ph(1'h0, d[i]);
      ph(1'h1, d[i]);
      q[i] = sda_w;
    end
  endtask : xfer
  // pointer, then one data byte or a restart and one read byte ended by nack
  task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic ok);
    logic [8:0] s0, s1, s2, s3;
    cond(1'h0);
    xfer({cha_pkg::DEV_ADDR_DEFAULT, 2'h1}, s0);
    xfer({a, 1'h1}, s1);
    if (rd) begin
      cond(1'h0);
      xfer({cha_pkg::DEV_ADDR_DEFAULT, 2'h3}, s2);
      xfer(9'h1FF, s3);
    end else begin
      xfer({d, 1'h1}, s2);
    end
    cond(1'h1);
    q = s3[8:1];
    ok = !(s0[0] | s1[0] | s2[0]);
  endtask : acc
endmodule : cha_host_model

// ---- bench/cha_charger_regs_chk.sv ----
// Purpose: port checks for the charger register bank
// Assumes: one clock, synchronous active-high reset
// Notes:   4-cycle holds cover the state and output lag
`timescale 1ns/10ps
module cha_charger_regs_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic supply_ok,
  input wire logic batt_low_v,
  input wire logic ntc_present,
  input wire logic batt_temp_ok,
  input wire logic charge_enable,
  input wire logic precharge_mode,
  input wire logic thermistor_curve_sel
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ****************************************
  // charge outputs and bus timing
  // ****************************************
  sequence s_no_supply;
    (!supply_ok) [*4];
  endsequence
  sequence s_batt_ok;
    (!batt_low_v) [*4];
  endsequence
  chk_off_no_supply: assert property (s_no_supply |-> !charge_enable && !precharge_mode)
    else $error("charger on without supply");
  chk_temp_hold: assert property ((!batt_temp_ok) [*4] |-> !charge_enable)
    else $error("charging with bad temperature");
  chk_sensor_hold: assert property ((!ntc_present) [*4] |-> !charge_enable)
    else $error("charging without sensor");
  chk_pre_leaves: assert property (s_batt_ok |-> !precharge_mode)
    else $error("precharge with battery above threshold");
  chk_pre_cause: assert property ($rose(precharge_mode) |-> $past(batt_low_v, 2) || $past(batt_low_v, 3))
    else $error("precharge without low battery");
  chk_reset_outs: assert property ($fell(srst) |-> thermistor_curve_sel && !charge_enable && !sda_oe)
    else $error("outputs not at reset values");
  chk_curve_quiet: assert property ($changed(thermistor_curve_sel) |-> !scl_in)
    else $error("curve select moved outside a write");
  chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
endmodule : cha_charger_regs_chk
bind cha_charger_regs cha_charger_regs_chk u_cha_charger_regs_chk (.clk, .srst, .scl_in, .sda_oe, .supply_ok,
  .batt_low_v, .ntc_present, .batt_temp_ok, .charge_enable, .precharge_mode, .thermistor_curve_sel);

// ---- bench/cha_charger_regs_tb.sv ----
// Purpose: self-checking bench for the charger register bank
// Assumes: tick shortened to 4 clk, so precharge limit is 7200 clk
// Notes:   timer waits are fixed by that shortened tick
`timescale 1ns/10ps
module cha_charger_regs_tb;
  logic       clk = 1'h0, srst = 1'h1, supply_ok = 1'h0, batt_low_v = 1'h0, ok;
  logic       term_current_det = 1'h0, thermal_loop_act = 1'h0, power_path_act = 1'h0;
  logic       ntc_present = 1'h1, batt_temp_ok = 1'h1;
  logic [7:0] q;
  logic [7:0] tsel [5] = '{8'h21, 8'h31, 8'h71, 8'hF1, 8'hB1};
  logic [7:0] frz [2] = '{8'hB3, 8'h91};
  wire        scl_in, sda_m, sda_oe, sda_out, charge_enable, precharge_mode, thermistor_curve_sel;
  wire        sda_in = sda_m & ~sda_oe; // pull-up unless someone pulls low
  int         miscompares = 0, checks = 0;
  cha_charger_regs #(.TICK_CYCLES(32'h4)) u_cha_charger_regs (.clk, .srst, .scl_in, .sda_in, .sda_out,
    .sda_oe, .supply_ok, .batt_low_v, .term_current_det, .thermal_loop_act, .power_path_act,
    .ntc_present, .batt_temp_ok, .charge_enable, .precharge_mode, .thermistor_curve_sel);
  cha_host_model u_cha_host_model (.clk, .sda_w(sda_in), .scl(scl_in), .sda_m);
  initial forever #2 clk = ~clk;
  // ****************************************
  // access and compare helpers
  // ****************************************
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_cha_host_model.acc(1'h0, a, d, q, ok);
    chk("write ack", {7'h0, ok}, 8'h01);
  endtask : w
  // read and compare only the bits under mask m
  task automatic r(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    u_cha_host_model.acc(1'h1, a, 8'h00, q, ok);
    chk("read ack", {7'h0, ok}, 8'h01);
    chk(n, q & m, e);
  endtask : r
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    chk("curve rst", {7'h0, thermistor_curve_sel}, 8'h01);
    chk("sda out", {7'h0, sda_out}, 8'h00);
    r(8'h04, 8'hFF, 8'hB1, "cfg rst");
    r(8'h03, 8'hFF, 8'h00, "st rst");
    w(8'h03, 8'hFF);
    r(8'h03, 8'hFF, 8'h00, "st ro");
    r(8'h07, 8'hFF, 8'h00, "unmapped");
    foreach (tsel[i]) begin
      w(8'h04, tsel[i]);
      r(8'h04, 8'hFF, tsel[i], "cfg rw");
      chk("curve", {7'h0, thermistor_curve_sel}, {7'h0, tsel[i][4]});
    end
    supply_ok <= 1'h1;
    r(8'h03, 8'hFF, 8'h08, "active");
    chk("chg on", {7'h0, charge_enable}, 8'h01);
    thermal_loop_act <= 1'h1;
    r(8'h03, 8'hFF, 8'h88, "thermal");
    power_path_act <= 1'h1;
    r(8'h03, 8'hFF, 8'hC8, "path");
    thermal_loop_act <= 1'h0;
    power_path_act <= 1'h0;
    batt_temp_ok <= 1'h0;
    r(8'h03, 8'h21, 8'h21, "temp hold");
    batt_temp_ok <= 1'h1;
    ntc_present <= 1'h0;
    r(8'h03, 8'h01, 8'h01, "no sensor");
    ntc_present <= 1'h1;
    r(8'h03, 8'hE9, 8'h08, "temp ok");
    w(8'h04, 8'hB5);
    term_current_det <= 1'h1;
    r(8'h03, 8'h18, 8'h08, "no term");
    w(8'h04, 8'hB1);
    r(8'h03, 8'h18, 8'h10, "term");
    chk("chg stop", {7'h0, charge_enable}, 8'h00);
    term_current_det <= 1'h0;
    w(8'h04, 8'hB9);
    r(8'h03, 8'h1C, 8'h00, "held");
    w(8'h04, 8'hB1);
    r(8'h03, 8'h1C, 8'h08, "restart");
    w(8'h04, 8'hB0);
    r(8'h03, 8'h08, 8'h00, "chg off");
    chk("chg off", {7'h0, charge_enable}, 8'h00);
    batt_low_v <= 1'h1;
    w(8'h04, 8'hB1);
    chk("pre", {7'h0, precharge_mode}, 8'h01);
    foreach (frz[i]) begin
      w(8'h04, frz[i]);
      repeat (7400) @(posedge clk);
      r(8'h03, 8'h06, 8'h00, "paused");
    end
    w(8'h04, 8'hB1);
    repeat (7400) @(posedge clk);
    r(8'h03, 8'h0E, 8'h06, "pre tout");
    summarize();
  end
endmodule : cha_charger_regs_tb
